/* core/quad_dac_serial_load_control.sv */
// Serial load control for a quad 12-bit converter: framed write/readback link,
// clear, simultaneous load and over-temperature alarm. Assumes all pins are
// asynchronous to mclk and the serial clock is well below mclk/6.
`timescale 1ns/1ps
`include "qdac_defines.svh"
module quad_dac_serial_load_control #(
  parameter int NUM_CH = 4
) (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic frame_sel_n, // Frame select from host
  input wire logic serial_clk, // Serial clock from host
  input wire logic serial_in, // Serial data in
  input wire logic async_zero_in_n, // Clear input
  input wire logic load_outputs_n, // Load strobe
  input wire logic over_temp, // Temperature monitor flag
  output logic serial_out, // Readback data
  output logic alarm_n, // Over-temperature alarm
  output logic [NUM_CH*`QDAC_CODE_W-1:0] dac_codes, // Converter registers
  output logic [NUM_CH-1:0] ch_powered // Channel amplifier enables
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic fs_lvl, fs_rise, fs_fall, sc_rise, sc_fall, sd_lvl, clr_lvl, clr_fall, ld_lvl, ot_lvl;
  pin_sync #(.INIT(1'b1)) u_fs (.mclk(mclk), .rst_n(rst_n), .pin(frame_sel_n),
    .level(fs_lvl), .rise(fs_rise), .fall(fs_fall));
  // Link clock idles high between frames; a low start would fake a rising edge after reset
  pin_sync #(.INIT(1'b1)) u_sc (.mclk(mclk), .rst_n(rst_n), .pin(serial_clk),
    .level(), .rise(sc_rise), .fall(sc_fall));
  pin_sync #(.INIT(1'b0)) u_sd (.mclk(mclk), .rst_n(rst_n), .pin(serial_in),
    .level(sd_lvl), .rise(), .fall());
  pin_sync #(.INIT(1'b1)) u_clr (.mclk(mclk), .rst_n(rst_n), .pin(async_zero_in_n),
    .level(clr_lvl), .rise(), .fall(clr_fall));
  pin_sync #(.INIT(1'b1)) u_ld (.mclk(mclk), .rst_n(rst_n), .pin(load_outputs_n),
    .level(ld_lvl), .rise(), .fall());
  pin_sync #(.INIT(1'b0)) u_ot (.mclk(mclk), .rst_n(rst_n), .pin(over_temp),
    .level(ot_lvl), .rise(), .fall());

  // ----------------------------------------
  // Frame state and shifter
  // ----------------------------------------
  qdac_pkg::frame_state_t state_reg;
  logic [`QDAC_FRAME_BITS-1:0] shift_reg;
  logic [4:0] count_reg;
  logic word_done;
  qdac_pkg::frame_word_t word;
  assign word = qdac_pkg::frame_word_t'({shift_reg[`QDAC_FRAME_BITS-2:0], sd_lvl});
  assign word_done = (state_reg == qdac_pkg::ST_SHIFT) && sc_fall && !fs_lvl &&
    (count_reg == 5'(`QDAC_FRAME_BITS - 1));

  // Frame sequencing; a frame ended early simply returns to idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= qdac_pkg::ST_IDLE;
      count_reg <= 5'h0;
      shift_reg <= 16'h0000;
    end else begin
      case (state_reg)
        qdac_pkg::ST_IDLE: begin
          if (fs_fall) begin
            state_reg <= qdac_pkg::ST_SHIFT;
            count_reg <= 5'h0;
          end
        end
        qdac_pkg::ST_SHIFT: begin
          if (fs_rise) begin
            state_reg <= qdac_pkg::ST_IDLE;
          end else if (sc_fall) begin
            shift_reg <= {shift_reg[`QDAC_FRAME_BITS-2:0], sd_lvl};
            count_reg <= count_reg + 5'h1;
            if (word_done) begin
              state_reg <= qdac_pkg::ST_DONE;
            end
          end
        end
        qdac_pkg::ST_DONE: begin
          if (fs_rise) begin
            state_reg <= qdac_pkg::ST_IDLE;
          end
        end
        default: state_reg <= qdac_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Input, converter and control registers
  // ----------------------------------------
  logic [`QDAC_CODE_W-1:0] in_reg [NUM_CH];
  logic [`QDAC_CODE_W-1:0] dac_reg [NUM_CH];
  logic [NUM_CH-1:0] new_reg;
  logic [7:0] ctrl_reg;
  logic ot_latch_reg;
  logic load_ok;
  logic ctrl_wr;
  // Clear low blocks loads; a held-low strobe loads continuously
  assign load_ok = !ld_lvl && clr_lvl;
  // A complete write frame addressed to the control word
  assign ctrl_wr = word_done && !word.read && (word.addr == `QDAC_ADDR_CTRL);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic wr_hit;
      assign wr_hit = word_done && !word.read && (word.addr == 3'(g + 1));
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          in_reg[g] <= `QDAC_CODE_ZERO;
          dac_reg[g] <= `QDAC_CODE_ZERO;
          new_reg[g] <= 1'b0;
        end else if (clr_fall) begin
          in_reg[g] <= `QDAC_CODE_ZERO;
          dac_reg[g] <= `QDAC_CODE_ZERO;
          new_reg[g] <= 1'b0;
        end else begin
          if (wr_hit) begin
            in_reg[g] <= word.data;
            new_reg[g] <= 1'b1;
          end else if (load_ok && new_reg[g]) begin
            dac_reg[g] <= in_reg[g];
            new_reg[g] <= 1'b0;
          end
        end
      end
      assign dac_codes[g*`QDAC_CODE_W +: `QDAC_CODE_W] = dac_reg[g];
    end
  endgenerate

  // Control register; over-temperature forces channels down until rewritten
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `QDAC_CTRL_RESET;
      ot_latch_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= word.data[7:0];
      end
      // A still-hot die wins over a power-up write, so no channel blips on
      if (ot_lvl) begin
        ot_latch_reg <= 1'b1;
      end else if (ctrl_wr) begin
        ot_latch_reg <= 1'b0;
      end
    end
  end

  // Outputs registered straight from flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_n <= 1'b1;
      ch_powered <= '0;
    end else begin
      alarm_n <= !ot_lvl;
      ch_powered <= ot_latch_reg ? '0 : ctrl_reg[`QDAC_CTRL_PU_MSB:`QDAC_CTRL_PU_LSB];
    end
  end

  // ----------------------------------------
  // Readback: loaded after a read frame, shifted on rising edges
  // ----------------------------------------
  logic [`QDAC_FRAME_BITS-1:0] rd_reg;
  logic [`QDAC_CODE_W-1:0] rd_sel;
  always_comb begin
    rd_sel = {4'h0, ctrl_reg};
    for (int i = 0; i < NUM_CH; i++) begin
      if (word.addr == 3'(i + 1)) begin
        rd_sel = dac_reg[i];
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg <= 16'h0000;
      serial_out <= 1'b0;
    end else begin
      if (word_done && word.read) begin
        rd_reg <= {4'h0, rd_sel};
      end else if (sc_rise && !fs_lvl) begin
        serial_out <= rd_reg[`QDAC_FRAME_BITS-1];
        rd_reg <= {rd_reg[`QDAC_FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  clear_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_fall |=> dac_codes == '0) else $error("clear did not zero codes");
  clear_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clr_lvl && !clr_fall |=> $stable(dac_codes)) else $error("load during clear");
  early_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_reg == qdac_pkg::ST_SHIFT && fs_rise |=> state_reg == qdac_pkg::ST_IDLE)
    else $error("early frame not dropped");
  extra_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_reg == qdac_pkg::ST_DONE |=> $stable(shift_reg) && $stable(count_reg))
    else $error("edge past sixteenth used");
  write_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !word_done && !clr_fall |=> $stable(in_reg[0])) else $error("write before sixteenth edge");
  readback_shift_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sc_rise && !fs_lvl |=> serial_out == $past(rd_reg[`QDAC_FRAME_BITS-1]))
    else $error("readback bit not shifted");
  shift_in_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_reg == qdac_pkg::ST_SHIFT && sc_fall && !fs_rise |=> shift_reg[0] == $past(sd_lvl))
    else $error("shifter missed bit");
  alarm_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ot_lvl |=> !alarm_n) else $error("alarm not raised");
  powerdown_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ot_latch_reg |=> ch_powered == '0) else $error("powered during shutdown");
  held_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    load_ok && new_reg[0] && !clr_fall && !g_ch[0].wr_hit |=> dac_reg[0] == $past(in_reg[0]))
    else $error("held load missed");
endmodule

/* core/qdac_defines.svh */
// Constants for the quad converter serial load control block.
// Assumes inclusion by bare name from core/ design files.
`ifndef QDAC_DEFINES_SVH
`define QDAC_DEFINES_SVH
`define QDAC_FRAME_BITS 16
`define QDAC_CODE_W 12
`define QDAC_CODE_ZERO 12'h000
`define QDAC_CTRL_RESET 8'h40
`define QDAC_CTRL_PU_LSB 2
`define QDAC_CTRL_PU_MSB 5
`define QDAC_RW_BIT 15
`define QDAC_ADDR_MSB 14
`define QDAC_ADDR_LSB 12
`define QDAC_ADDR_CTRL 3'h7
`endif

/* core/qdac_pkg.sv */
// Types for the quad converter serial load control block.
// Assumes qdac_defines.svh is available alongside.
package qdac_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } frame_state_t;
  typedef struct packed {
    logic read;
    logic [2:0] addr;
    logic [11:0] data;
  } frame_word_t;
endpackage

/* core/pin_sync.sv */
// Three-stage pin synchroniser with second/third-stage agreement.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ps
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic pin, // Raw pin
  output logic level, // Filtered level
  output logic rise, // One-cycle pulse on rise
  output logic fall // One-cycle pulse on fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // ----------------------------------------
  // Synchroniser chain and agreement filter
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      level <= INIT;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level <= s3_reg; // Change counts once two stages agree
      end
    end
  end
  // Edges derived from filtered level changes
  always_comb begin
    rise = (s2_reg == s3_reg) && s3_reg && !level;
    fall = (s2_reg == s3_reg) && !s3_reg && level;
  end
endmodule

/* tb/host_model.sv */
// Host side of the serial link: frames words onto the converter's write port.
// Assumes the bench calls frame() and leaves the idle wait between frames to it.
`timescale 1ns/1ps
module host_model (
  output logic frame_sel_n, // Frame select, active low
  output logic serial_clk, // Link clock, still between frames
  output logic serial_in, // Data towards the device
  input wire logic serial_out // Readback bit from the device
);
  // --------------------------------------------------------------------------
  // Link state
  // --------------------------------------------------------------------------
  logic [15:0] rx_word;
  initial begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b1;
    serial_in = 1'b0;
    rx_word = 16'h0000;
  end
  // One frame of a 160 ns link clock; edges below 16 end the frame early
  // Data is set mid-high and held through the fall; readback sampled at falls
  task automatic frame(input logic [15:0] word, input int edges);
    frame_sel_n = 1'b0;
    #80;
    for (int i = 0; i < edges; i++) begin
      serial_in = word[4'(15 - i)];
      #40 serial_clk = 1'b0;
      rx_word = {rx_word[14:0], serial_out};
      #80 serial_clk = 1'b1;
      #40;
    end
    // Released line shows the inverse, so a stale bit never reads as valid
    serial_in = ~serial_in;
    #80 frame_sel_n = 1'b1;
    #320;
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the quad converter serial load control block.
// Assumes host_model drives the link; the bench drives clear, load and temperature.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top;
  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  logic mclk, rst_n, async_zero_in_n, load_outputs_n, over_temp;
  logic frame_sel_n, serial_clk, serial_in, serial_out, alarm_n;
  logic [47:0] dac_codes;
  logic [3:0] ch_powered;
  int error_cnt = 0;
  int num_checks = 0;
  quad_dac_serial_load_control dut (.mclk(mclk), .rst_n(rst_n), .frame_sel_n(frame_sel_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .async_zero_in_n(async_zero_in_n),
    .load_outputs_n(load_outputs_n), .over_temp(over_temp), .serial_out(serial_out),
    .alarm_n(alarm_n), .dac_codes(dac_codes), .ch_powered(ch_powered));
  host_model host (.frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out));
  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  // Inputs change 1 ns after a rising edge, clear of the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Write frame; the wait covers the pin synchronisers' latency
  task automatic wr(input logic [2:0] addr, input logic [11:0] data);
    host.frame({1'b0, addr, data}, 16);
    cyc(10);
  endtask
  task automatic pulse_load();
    load_outputs_n = 1'b0;
    cyc(8);
    load_outputs_n = 1'b1;
    cyc(8);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    `CHK("dac_codes", 48'h0000_0000_0000, dac_codes)
    `CHK("ch_powered", 4'h0, ch_powered)
    `CHK("alarm_n", 1'b1, alarm_n)
    $display("done reset");
  endtask
  // Two channels staged, a read frame between, then one strobe moves both
  task automatic t_load();
    wr(3'h1, 12'hABC);
    wr(3'h4, 12'h123);
    host.frame({1'b1, 3'h1, 12'h0000}, 16);
    cyc(10);
    `CHK("dac staged", 48'h0000_0000_0000, dac_codes)
    pulse_load();
    `CHK("dac loaded", 48'h1230_0000_0ABC, dac_codes)
    $display("done load");
  endtask
  // A read frame stages a word; its 16th rising edge shifts out the MSB, the next frame's rising edges the rest
  task automatic t_read();
    host.frame({1'b1, 3'h1, 12'h000}, 16);
    host.frame({1'b1, 3'h7, 12'h000}, 16);
    `CHK("readback ch0", 16'h0ABC, host.rx_word)
    host.frame({1'b1, 3'h7, 12'h000}, 16);
    `CHK("readback ctrl", 16'h0040, host.rx_word)
    $display("done read");
  endtask
  // Frame cut one edge short must leave the input and converter registers alone
  task automatic t_abort();
    host.frame({1'b0, 3'h1, 12'h555}, 15);
    cyc(10);
    pulse_load();
    `CHK("dac aborted", 48'h1230_0000_0ABC, dac_codes)
    $display("done abort");
  endtask
  // Load held low, frame with four surplus edges carrying other bits
  task automatic t_extra();
    load_outputs_n = 1'b0;
    host.frame({1'b0, 3'h2, 12'h5A5}, 20);
    cyc(10);
    `CHK("dac ch1", 12'h5A5, dac_codes[23:12])
    load_outputs_n = 1'b1;
    cyc(4);
    $display("done extra");
  endtask
  // Clear zeroes once at its fall; strobes are lost while it stays low
  task automatic t_clear();
    async_zero_in_n = 1'b0;
    cyc(10);
    `CHK("dac cleared", 48'h0000_0000_0000, dac_codes)
    wr(3'h3, 12'h777);
    pulse_load();
    `CHK("dac held", 48'h0000_0000_0000, dac_codes)
    async_zero_in_n = 1'b1;
    cyc(10);
    pulse_load();
    `CHK("dac after clear", 48'h0007_7700_0000, dac_codes)
    $display("done clear");
  endtask
  // Over-temperature latches power-down until the control word is written again
  task automatic t_temp();
    wr(3'h7, 12'h03C);
    `CHK("ch_powered on", 4'hF, ch_powered)
    over_temp = 1'b1;
    cyc(10);
    `CHK("alarm_n hot", 1'b0, alarm_n)
    `CHK("ch_powered hot", 4'h0, ch_powered)
    over_temp = 1'b0;
    cyc(10);
    `CHK("alarm_n cool", 1'b1, alarm_n)
    `CHK("ch_powered latched", 4'h0, ch_powered)
    wr(3'h7, 12'h03C);
    `CHK("ch_powered again", 4'hF, ch_powered)
    $display("done temp");
  endtask
  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    async_zero_in_n = 1'b1;
    load_outputs_n = 1'b1;
    over_temp = 1'b0;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    cyc(6);
    t_reset();
    t_load();
    t_read();
    t_abort();
    t_extra();
    t_clear();
    t_temp();
    test_done();
  end
  // About eleven frames of 3 us each, with generous margin
  initial begin
    #300000;
    error_cnt++;
    test_done();
  end
endmodule
